// ===== hw/isd_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "isd_defines.svh"
// Contract
// - 9-bit status at 0x04 with master-read flag.
// - tx pending while queued bytes remain unread.
// - early end of slave send sets NACK.
// - 10-bit interrupt status at 0x10, write-one-clear.
// - readable mask at 0x20; set bit disables.
// - DATA bit flags master wanting more service.
// - rx valid while bytes held; data read pops.
// - enable register at 0x24 clears mask bits.
module isd_core
  import isd_pkg::*;
#(
  parameter int DEPTH = 4
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  output logic o_irq,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = AW + 1;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  function automatic logic [CW-1:0] cnt_step(input logic [CW-1:0] c, input logic up, input logic dn);
    return c + CW'(up) - CW'(dn);
  endfunction

  logic scl_rise;
  logic scl_fall;
  logic sda_s;
  logic start_det;
  logic stop_det;

  isd_pin_sync u_pin_sync (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_scl_rise(scl_rise),
    .o_scl_fall(scl_fall),
    .o_sda(sda_s),
    .o_start(start_det),
    .o_stop(stop_det)
  );

  isd_state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic sda_oe_r;
  logic addressed_r;
  logic master_read_r;
  logic bus_active_r;
  logic nack_seen_r;
  logic [6:0] own_addr_r;

  logic ev_comp_r;
  logic ev_data_r;
  logic ev_nack_r;
  logic ev_rx_ovf_r;
  logic rx_push_r;
  logic tx_pop_r;

  logic [7:0] tx_mem_r [DEPTH];
  logic [AW-1:0] tx_wp_r;
  logic [AW-1:0] tx_rp_r;
  logic [CW-1:0] tx_cnt_r;
  logic [7:0] rx_mem_r [DEPTH];
  logic [AW-1:0] rx_wp_r;
  logic [AW-1:0] rx_rp_r;
  logic [CW-1:0] rx_cnt_r;

  logic [`ISD_IRQ_W-1:0] isr_r;
  logic [`ISD_IRQ_W-1:0] imr_r;
  logic [`ISD_IRQ_W-1:0] isr_set;
  logic [`ISD_IRQ_W-1:0] isr_clr;
  logic [`ISD_STATUS_W-1:0] status_vec;

  logic wr_data;
  logic rd_data;
  logic tx_full;
  logic tx_empty;
  logic rx_full;
  logic rx_empty;
  logic tx_push;
  logic rx_pop;
  logic ev_tx_ovf;
  logic ev_rx_unf;
  logic [7:0] tx_head;

  assign wr_data = i_reg_wr && (i_reg_addr == `ISD_OFS_DATA);
  assign rd_data = i_reg_rd && (i_reg_addr == `ISD_OFS_DATA);
  assign tx_full = (tx_cnt_r == CW'(DEPTH));
  assign tx_empty = (tx_cnt_r == '0);
  assign rx_full = (rx_cnt_r == CW'(DEPTH));
  assign rx_empty = (rx_cnt_r == '0);
  assign tx_push = wr_data && !tx_full;
  assign rx_pop = rd_data && !rx_empty;
  assign ev_tx_ovf = wr_data && tx_full;
  assign ev_rx_unf = rd_data && rx_empty;
  // An empty queue answers the master with all ones and asks software for data.
  assign tx_head = tx_empty ? `ISD_IDLE_BYTE : tx_mem_r[tx_rp_r];

  // Serial link state machine; the slave never stretches SCL.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= ISD_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      sda_oe_r <= 1'b0;
      addressed_r <= 1'b0;
      master_read_r <= 1'b0;
      bus_active_r <= 1'b0;
      nack_seen_r <= 1'b0;
      ev_comp_r <= 1'b0;
      ev_data_r <= 1'b0;
      ev_nack_r <= 1'b0;
      ev_rx_ovf_r <= 1'b0;
      rx_push_r <= 1'b0;
      tx_pop_r <= 1'b0;
    end else begin
      ev_comp_r <= 1'b0;
      ev_data_r <= 1'b0;
      ev_nack_r <= 1'b0;
      ev_rx_ovf_r <= 1'b0;
      rx_push_r <= 1'b0;
      tx_pop_r <= 1'b0;
      if (start_det) begin
        // A repeated start also closes the previous addressed transfer.
        ev_comp_r <= addressed_r;
        state_r <= ISD_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oe_r <= 1'b0;
        addressed_r <= 1'b0;
        master_read_r <= 1'b0;
        bus_active_r <= 1'b1;
      end else if (stop_det) begin
        ev_comp_r <= addressed_r;
        state_r <= ISD_IDLE;
        sda_oe_r <= 1'b0;
        addressed_r <= 1'b0;
        master_read_r <= 1'b0;
        bus_active_r <= 1'b0;
      end else begin
        case (state_r)
          ISD_ADDR: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_s};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == 4'h8) begin
              bit_cnt_r <= 4'h0;
              if (shift_r[7:1] == own_addr_r) begin
                addressed_r <= 1'b1;
                master_read_r <= shift_r[0];
                sda_oe_r <= 1'b1;
                state_r <= ISD_AACK;
              end else begin
                state_r <= ISD_IDLE;
              end
            end
          end
          ISD_AACK: begin
            if (scl_fall) begin
              if (master_read_r) begin
                shift_r <= tx_head;
                sda_oe_r <= ~tx_head[7];
                tx_pop_r <= !tx_empty;
                ev_data_r <= tx_empty;
                state_r <= ISD_TXB;
              end else begin
                sda_oe_r <= 1'b0;
                state_r <= ISD_RXB;
              end
            end
          end
          ISD_TXB: begin
            if (scl_fall) begin
              if (bit_cnt_r == 4'h7) begin
                bit_cnt_r <= 4'h0;
                sda_oe_r <= 1'b0;
                state_r <= ISD_TACK;
              end else begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
                shift_r <= {shift_r[6:0], 1'b0};
                sda_oe_r <= ~shift_r[6];
              end
            end
          end
          ISD_TACK: begin
            if (scl_rise) begin
              nack_seen_r <= sda_s;
            end else if (scl_fall) begin
              if (nack_seen_r) begin
                ev_nack_r <= !tx_empty;
                state_r <= ISD_IDLE;
              end else begin
                shift_r <= tx_head;
                sda_oe_r <= ~tx_head[7];
                tx_pop_r <= !tx_empty;
                ev_data_r <= tx_empty;
                state_r <= ISD_TXB;
              end
            end
          end
          ISD_RXB: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_s};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == 4'h8) begin
              bit_cnt_r <= 4'h0;
              if (rx_full) begin
                // No room: leave SDA released so the master sees a not-acknowledge.
                ev_rx_ovf_r <= 1'b1;
                state_r <= ISD_IDLE;
              end else begin
                rx_push_r <= 1'b1;
                ev_data_r <= (rx_cnt_r == CW'(DEPTH - 1));
                sda_oe_r <= 1'b1;
                state_r <= ISD_RACK;
              end
            end
          end
          ISD_RACK: begin
            if (scl_fall) begin
              sda_oe_r <= 1'b0;
              state_r <= ISD_RXB;
            end
          end
          default: begin
            sda_oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // Transmit queue: software fills it, the link drains it.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_wp_r <= '0;
      tx_rp_r <= '0;
      tx_cnt_r <= '0;
    end else begin
      if (tx_push) begin
        tx_wp_r <= ptr_inc(tx_wp_r);
      end
      if (tx_pop_r) begin
        tx_rp_r <= ptr_inc(tx_rp_r);
      end
      tx_cnt_r <= cnt_step(tx_cnt_r, tx_push, tx_pop_r);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (tx_push) begin
      tx_mem_r[tx_wp_r] <= i_reg_wdata[7:0];
    end
  end

  // Receive queue: the link fills it, data port reads drain it.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_wp_r <= '0;
      rx_rp_r <= '0;
      rx_cnt_r <= '0;
    end else begin
      if (rx_push_r) begin
        rx_wp_r <= ptr_inc(rx_wp_r);
      end
      if (rx_pop) begin
        rx_rp_r <= ptr_inc(rx_rp_r);
      end
      rx_cnt_r <= cnt_step(rx_cnt_r, rx_push_r, rx_pop);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (rx_push_r) begin
      rx_mem_r[rx_wp_r] <= shift_r;
    end
  end

  // Own slave address, software programmable.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      own_addr_r <= `ISD_OWN_ADDR_RST;
    end else if (i_reg_wr && i_reg_addr == `ISD_OFS_OWN_ADDR) begin
      own_addr_r <= i_reg_wdata[6:0];
    end
  end

  always_comb begin
    isr_set = '0;
    isr_set[`ISD_IRQ_COMP] = ev_comp_r;
    isr_set[`ISD_IRQ_DATA] = ev_data_r;
    isr_set[`ISD_IRQ_NACK] = ev_nack_r;
    isr_set[`ISD_IRQ_RX_OVF] = ev_rx_ovf_r;
    isr_set[`ISD_IRQ_TX_OVF] = ev_tx_ovf;
    isr_set[`ISD_IRQ_RX_UNF] = ev_rx_unf;
  end

  assign isr_clr = (i_reg_wr && i_reg_addr == `ISD_OFS_ISR) ? i_reg_wdata[`ISD_IRQ_W-1:0] : '0;

  // A new event in the clearing cycle survives the clear.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      isr_r <= '0;
    end else begin
      isr_r <= (isr_r & ~isr_clr) | isr_set;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      imr_r <= `ISD_IMR_RST;
    end else if (i_reg_wr && i_reg_addr == `ISD_OFS_IER) begin
      imr_r <= imr_r & ~i_reg_wdata[`ISD_IRQ_W-1:0];
    end else if (i_reg_wr && i_reg_addr == `ISD_OFS_IDR) begin
      imr_r <= imr_r | i_reg_wdata[`ISD_IRQ_W-1:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(isr_r & ~imr_r);
    end
  end

  always_comb begin
    status_vec = '0;
    status_vec[`ISD_ST_MASTER_READ] = master_read_r;
    status_vec[`ISD_ST_RX_VALID] = !rx_empty;
    status_vec[`ISD_ST_TX_PENDING] = !tx_empty;
    status_vec[`ISD_ST_RX_FULL] = rx_full;
    status_vec[`ISD_ST_BUS_ACTIVE] = bus_active_r;
  end

  // Read data stands for the one cycle after the read strobe, zero otherwise.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 32'h0000_0000;
    end else if (!i_reg_rd) begin
      o_reg_rdata <= 32'h0000_0000;
    end else if (i_reg_addr == `ISD_OFS_STATUS) begin
      o_reg_rdata <= {23'h00_0000, status_vec};
    end else if (i_reg_addr == `ISD_OFS_OWN_ADDR) begin
      o_reg_rdata <= {25'h000_0000, own_addr_r};
    end else if (i_reg_addr == `ISD_OFS_DATA) begin
      o_reg_rdata <= {24'h00_0000, rx_empty ? 8'h00 : rx_mem_r[rx_rp_r]};
    end else if (i_reg_addr == `ISD_OFS_ISR) begin
      o_reg_rdata <= {22'h00_0000, isr_r};
    end else if (i_reg_addr == `ISD_OFS_IMR) begin
      o_reg_rdata <= {22'h00_0000, imr_r};
    end else begin
      o_reg_rdata <= 32'h0000_0000;
    end
  end

  assign o_sda_o = 1'b0;
  assign o_sda_oe = sda_oe_r;

endmodule // isd_core
`default_nettype wire

// ===== hw/isd_defines.svh
`ifndef ISD_DEFINES_SVH
`define ISD_DEFINES_SVH

// Register offsets on the byte-addressed register port.
`define ISD_OFS_STATUS 8'h04
`define ISD_OFS_OWN_ADDR 8'h08
`define ISD_OFS_DATA 8'h0C
`define ISD_OFS_ISR 8'h10
`define ISD_OFS_IMR 8'h20
`define ISD_OFS_IER 8'h24
`define ISD_OFS_IDR 8'h28

// Register widths.
`define ISD_STATUS_W 9
`define ISD_IRQ_W 10
`define ISD_DATA_W 8

// Status register bit positions.
`define ISD_ST_MASTER_READ 3
`define ISD_ST_RX_VALID 5
`define ISD_ST_TX_PENDING 6
`define ISD_ST_RX_FULL 7
`define ISD_ST_BUS_ACTIVE 8

// Interrupt status bit positions.
`define ISD_IRQ_COMP 0
`define ISD_IRQ_DATA 1
`define ISD_IRQ_NACK 2
`define ISD_IRQ_RX_OVF 5
`define ISD_IRQ_TX_OVF 6
`define ISD_IRQ_RX_UNF 7

// Reset values, and the byte sent from an empty transmit queue.
`define ISD_IMR_RST 10'h2FF
`define ISD_OWN_ADDR_RST 7'h2A
`define ISD_IDLE_BYTE 8'hFF

`endif

// ===== hw/isd_pkg.sv
package isd_pkg;

  // Link state, Gray coded along address, acknowledge and byte phases.
  typedef enum logic [2:0] {
    ISD_IDLE = 3'b000,
    ISD_ADDR = 3'b001,
    ISD_AACK = 3'b011,
    ISD_RXB = 3'b010,
    ISD_RACK = 3'b110,
    ISD_TXB = 3'b111,
    ISD_TACK = 3'b101
  } isd_state_t;

endpackage

// ===== hw/isd_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module isd_pin_sync (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_rise,
  output logic o_scl_fall,
  output logic o_sda,
  output logic o_start,
  output logic o_stop
);

  logic [1:0] scl_meta_r;
  logic [1:0] sda_meta_r;
  logic scl_last_r;
  logic sda_last_r;

  // Three flops per pin; the first stage feeds only the second, the third holds the last value for edge detection.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_meta_r <= 2'b11;
      sda_meta_r <= 2'b11;
      scl_last_r <= 1'b1;
      sda_last_r <= 1'b1;
    end else begin
      scl_meta_r <= {scl_meta_r[0], i_scl};
      sda_meta_r <= {sda_meta_r[0], i_sda};
      scl_last_r <= scl_meta_r[1];
      sda_last_r <= sda_meta_r[1];
    end
  end

  assign o_scl_rise = scl_meta_r[1] & ~scl_last_r;
  assign o_scl_fall = ~scl_meta_r[1] & scl_last_r;
  assign o_sda = sda_meta_r[1];
  // SDA moving while SCL stays high marks start and stop conditions.
  assign o_start = scl_meta_r[1] & scl_last_r & ~sda_meta_r[1] & sda_last_r;
  assign o_stop = scl_meta_r[1] & scl_last_r & sda_meta_r[1] & ~sda_last_r;

endmodule // isd_pin_sync
`default_nettype wire

// ===== dv/isd_checker.sv
`timescale 1ns/1ps
`default_nettype none
module isd_checker (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  input wire logic o_irq,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_o,
  input wire logic o_sda_oe
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  logic en_seen_r;
  // Until software has enabled a source, every event source is masked.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b)
      en_seen_r <= 1'b0;
    else if (i_reg_wr && i_reg_addr == 8'h24 && i_reg_wdata[9:0] != 10'h000)
      en_seen_r <= 1'b1;
  end
  a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == '0)
    else $error("read data not zero outside read cycle");
  a_status_width: assert property ($past(i_reg_rd) && $past(i_reg_addr) == 8'h04 |-> o_reg_rdata[31:9] == '0)
    else $error("status read wider than nine bits");
  a_isr_width: assert property ($past(i_reg_rd) && $past(i_reg_addr) == 8'h10 |-> o_reg_rdata[31:10] == '0)
    else $error("event status read wider than ten bits");
  a_mask_width: assert property ($past(i_reg_rd) && $past(i_reg_addr) == 8'h20 |-> o_reg_rdata[31:10] == '0)
    else $error("mask read wider than ten bits");
  a_irq_masked: assert property (!en_seen_r |-> !o_irq)
    else $error("interrupt raised with all sources masked");
  a_mask_quiet: assert property (i_reg_wr && i_reg_addr == 8'h28 && i_reg_wdata[9:0] == 10'h3FF |-> ##2 !o_irq)
    else $error("interrupt stays high after masking all");
  a_isr_sticky: assert property ($past(i_reg_rd, 3) && $past(i_reg_addr, 3) == 8'h10 && !$past(i_reg_wr, 2)
    && $past(i_reg_rd) && $past(i_reg_addr) == 8'h10
    |-> (o_reg_rdata & $past(o_reg_rdata, 2)) == $past(o_reg_rdata, 2))
    else $error("event bit lost without a clear");
  a_w1c_keep: assert property ($past(i_reg_rd, 5) && $past(i_reg_addr, 5) == 8'h10
    && $past(i_reg_wr, 3) && $past(i_reg_addr, 3) == 8'h10 && $past(i_reg_rd) && $past(i_reg_addr) == 8'h10
    |-> (o_reg_rdata & $past(o_reg_rdata, 4) & ~$past(i_reg_wdata, 3)) == ($past(o_reg_rdata, 4) & ~$past(i_reg_wdata, 3)))
    else $error("clear write touched bits written as zero");
endmodule // isd_checker
bind isd_core isd_checker u_chk (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_irq(o_irq),
  .i_scl(i_scl), .i_sda(i_sda), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe));
`default_nettype wire

// ===== dv/isd_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none
module isd_i2c_master (
  output logic o_scl,
  output logic o_sda_low,
  input wire logic i_sda
);
  int half_ns = 100;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // Data moves a quarter of half_ns after SCL falls, never while SCL is high.
  task automatic bit_io(input logic b, output logic r);
    #(half_ns / 4) o_sda_low = !b;
    #(half_ns * 3 / 4) o_scl = 1'b1;
    #(half_ns / 2) r = i_sda;
    #(half_ns / 2) o_scl = 1'b0;
  endtask
  // The extra nanosecond keeps pin changes off the core clock edges while tasks run back to back after start.
  task automatic start();
    #(half_ns / 4 + 1) o_sda_low = 1'b0;
    #(half_ns) o_scl = 1'b1;
    #(half_ns) o_sda_low = 1'b1;
    #(half_ns) o_scl = 1'b0;
  endtask
  task automatic stop();
    #(half_ns / 4) o_sda_low = 1'b1;
    #(half_ns) o_scl = 1'b1;
    #(half_ns) o_sda_low = 1'b0;
    #(half_ns);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic nak);
    logic x;
    for (int i = 7; i >= 0; i--) bit_io(d[i], x);
    bit_io(1'b1, nak);
  endtask
  task automatic rbyte(input logic nak, output logic [7:0] d);
    logic x;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nak, x);
  endtask
endmodule // isd_i2c_master
`default_nettype wire

// ===== dv/isd_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module isd_core_tb_top;
  logic i_core_clk, i_rst_b, i_reg_wr, i_reg_rd, o_irq, o_sda_o, o_sda_oe, scl, m_low, sda, nak;
  logic [7:0] i_reg_addr, b0, b1, got;
  logic [31:0] i_reg_wdata, o_reg_rdata, rv;
  logic [7:0] q [4];
  int fail_count = 0;
  int tests_run = 0;
  int seed = 71;
  // Open-drain wire with a pull-up.
  assign sda = !(m_low || (o_sda_oe && !o_sda_o));
  isd_core #(.DEPTH(4)) u_dut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .o_irq(o_irq), .i_scl(scl), .i_sda(sda), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe));
  isd_i2c_master u_mst (.o_scl(scl), .o_sda_low(m_low), .i_sda(sda));
  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = !i_core_clk;
  end
  task automatic give_verdict();
    if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
    @(posedge i_core_clk);
  endtask
  task automatic cr(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_core_clk);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
    @(posedge i_core_clk);
    check($sformatf("reg %h", a), exp, d);
  endtask
  // Enable writes clear mask bits; only ten mask bits exist.
  function automatic logic [31:0] mask_exp(input logic [31:0] m, input logic [31:0] en);
    return m & ~en & 32'h0000_03FF;
  endfunction
  task automatic settle();
    repeat (8) @(posedge i_core_clk);
  endtask
  initial begin
    #1_000_000;
    fail_count++;
    give_verdict();
  end
  initial begin
    i_rst_b = 1'b0;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    i_reg_addr = 8'h00;
    i_reg_wdata = '0;
    repeat (3) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    @(posedge i_core_clk);
    cr(8'h20, 32'h2FF);
    cr(8'h10, 32'h000);
    wr(8'h04, '1);
    cr(8'h04, 32'h000);
    wr(8'h30, '1);
    cr(8'h30, 32'h000);
    rv = $random(seed) & 32'h3FF;
    wr(8'h24, rv);
    cr(8'h20, mask_exp(32'h2FF, rv));
    wr(8'h24, 32'h000);
    cr(8'h20, mask_exp(32'h2FF, rv));
    wr(8'h28, 32'h3FF);
    cr(8'h20, 32'h3FF);
    b0 = 8'($random(seed));
    b1 = 8'($random(seed));
    u_mst.start();
    u_mst.wbyte(8'h56, nak);
    u_mst.stop();
    check("foreign address ack", 1, nak);
    u_mst.start();
    u_mst.wbyte(8'h54, nak);
    check("own address ack", 0, nak);
    u_mst.wbyte(b0, nak);
    u_mst.wbyte(b1, nak);
    u_mst.stop();
    settle();
    cr(8'h04, 32'h020);
    cr(8'h0C, {24'h0, b0});
    cr(8'h0C, {24'h0, b1});
    cr(8'h04, 32'h000);
    cr(8'h0C, 32'h000);
    cr(8'h10, 32'h081);
    wr(8'h10, 32'h001);
    cr(8'h10, 32'h080);
    wr(8'h10, 32'h080);
    cr(8'h10, 32'h000);
    wr(8'h24, 32'h007);
    wr(8'h0C, {24'h0, b0});
    wr(8'h0C, {24'h0, b1});
    cr(8'h04, 32'h040);
    u_mst.start();
    u_mst.wbyte(8'h55, nak);
    settle();
    cr(8'h04, 32'h148);
    u_mst.rbyte(1'b1, got);
    check("sent byte", {24'h0, b0}, {24'h0, got});
    u_mst.stop();
    settle();
    cr(8'h10, 32'h005);
    cr(8'h10, 32'h005);
    check("interrupt", 1, o_irq);
    cr(8'h04, 32'h040);
    wr(8'h10, '1);
    u_mst.half_ns = 300;
    u_mst.start();
    u_mst.wbyte(8'h55, nak);
    u_mst.rbyte(1'b0, got);
    check("sent byte", {24'h0, b1}, {24'h0, got});
    u_mst.rbyte(1'b1, got);
    u_mst.stop();
    u_mst.half_ns = 100;
    settle();
    cr(8'h10, 32'h003);
    cr(8'h04, 32'h000);
    check("interrupt", 1, o_irq);
    wr(8'h28, 32'h3FF);
    @(posedge i_core_clk);
    check("interrupt", 0, o_irq);
    wr(8'h10, '1);
    cr(8'h10, 32'h000);
    for (int i = 0; i < 5; i++) wr(8'h0C, 32'h0A0 + i);
    cr(8'h10, 32'h040);
    cr(8'h04, 32'h040);
    wr(8'h10, '1);
    u_mst.start();
    u_mst.wbyte(8'h54, nak);
    for (int i = 0; i < 5; i++) begin
      rv = $random(seed);
      if (i < 4) q[i] = rv[7:0];
      u_mst.wbyte(rv[7:0], nak);
    end
    check("overflow byte ack", 1, nak);
    u_mst.stop();
    settle();
    cr(8'h04, 32'h0E0);
    cr(8'h10, 32'h023);
    for (int i = 0; i < 4; i++) cr(8'h0C, {24'h00_0000, q[i]});
    wr(8'h10, '1);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    @(posedge i_core_clk);
    cr(8'h04, 32'h000);
    cr(8'h20, 32'h2FF);
    cr(8'h10, 32'h000);
    give_verdict();
  end
endmodule // isd_core_tb_top
`default_nettype wire
